// ===== hdl/hbif_pkg.sv
// Purpose: Shared constants for the half-bridge interlock and fault block
// Assumes: ref_clk at 25 MHz
// Notes:   Times are kept in ns, cycle counts derive from them
package hbif_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int DEAD_TIME_NS   = 400;
	// Least time: round up, at least one cycle
	localparam int DEAD_CYCLES_I  = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_CYCLES    = (DEAD_CYCLES_I < 1) ? 1 : DEAD_CYCLES_I;
	localparam int DEAD_CNT_W     = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic RST_GATE  = 1'b0;
	localparam logic RST_FLAG  = 1'b0;
endpackage

// ===== hdl/hbif_dead_timer.sv
// Purpose: Dead-time counter that restarts in every cycle its restart input is high
// Assumes: Trigger synchronous to ref_clk
// Notes:   done rises DEAD_CYCLES cycles after the last restart
`timescale 1ns/1ps
`default_nettype none
module hbif_dead_timer #(
	parameter int CYCLES = hbif_pkg::DEAD_CYCLES,
	parameter int W      = hbif_pkg::DEAD_CNT_W
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic clk_en,
	input  wire logic restart,
	output logic      done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} hbif_dt_state_t;

	hbif_dt_state_t st_r;
	hbif_dt_state_t st_nxt;

	// Count up to CYCLES and hold; restart clears the count
	always_comb begin
		st_nxt = st_r;
		if (restart) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt != W'(CYCLES)) begin
			st_nxt.cnt = st_r.cnt + W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r.cnt <= W'(CYCLES);
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign done = (st_r.cnt == W'(CYCLES)) && !restart;
endmodule
`default_nettype wire

// ===== hdl/hbif_fault_latch.sv
// Purpose: Sticky fault flag with host clear
// Assumes: Condition and clear synchronous to ref_clk
// Notes:   A live condition wins over the clear
`timescale 1ns/1ps
`default_nettype none
module hbif_fault_latch (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic clk_en,
	input  wire logic cond,
	input  wire logic clear,
	output logic      flag
);
	typedef struct packed {
		logic flag;
	} hbif_fl_state_t;

	hbif_fl_state_t st_r;
	hbif_fl_state_t st_nxt;

	// Set wins over clear so no event is lost
	always_comb begin
		st_nxt = st_r;
		if (cond) begin
			st_nxt.flag = 1'b1;
		end else if (clear) begin
			st_nxt.flag = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r.flag <= hbif_pkg::RST_FLAG;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;
endmodule
`default_nettype wire

// ===== hdl/hbif_top.sv
// Purpose: Gate interlock with dead time, and fault shutdown for two channels
// Assumes: All inputs synchronous to ref_clk; comparators arrive as levels
// Notes:   Channel A has priority; both gates blocked during supply or over-temperature lockout
//
// Operation
// - B on and A command rises: drop B at once.
// - After A preempts B, A turns on after the dead time.
// - A falls with B command high: B turns on after dead time.
// - While A active, B command is ignored and B held off.
// - B pending when A falls turns on about 400 ns later.
// - Over 150 C both gates off until below 125 C.
// - Over-current drops that gate at once and is reported.
// - Supply fault on any side blocks gates and is reported.
// - Active-clamp trip disables that channel's driver.
// - Driver fault flags stay latched for the host to read.
`timescale 1ns/1ps
`default_nettype none
module hbif_top (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic clk_en,
	input  wire logic channel_a_command,
	input  wire logic channel_b_command,
	input  wire logic fault_clear_input,
	input  wire logic overcurrent_a,
	input  wire logic overcurrent_b,
	input  wire logic clamp_trip_a,
	input  wire logic clamp_trip_b,
	input  wire logic supply_fault_primary,
	input  wire logic supply_fault_a,
	input  wire logic supply_fault_b,
	input  wire logic temp_above_high,
	input  wire logic temp_below_low,
	output logic      gate_a,
	output logic      gate_b,
	output logic      first_driver_fault_flag,
	output logic      second_driver_fault_flag,
	output logic      overtemp_flag
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cmd_a_q;
		logic gate_a;
		logic gate_b;
		logic overtemp;
		logic oc_hold_a;
		logic oc_hold_b;
	} hbif_state_t;

	hbif_state_t st_r;
	hbif_state_t st_nxt;

	logic a_edge;
	logic a_done;
	logic b_done;
	logic block_all;
	logic stop_a;
	logic stop_b;
	logic cond_a;
	logic cond_b;

	// ----------------------------------------------------------------
	// Dead-time timers
	// ----------------------------------------------------------------
	// Any change of the A command restarts both timers
	assign a_edge = channel_a_command != st_r.cmd_a_q;

	// A waits the dead time after every A command change and after B goes off
	hbif_dead_timer u_dt_a (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.restart (a_edge || st_r.gate_b),
		.done    (a_done)
	);

	// B waits the dead time from A going inactive
	hbif_dead_timer u_dt_b (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.restart (a_edge || channel_a_command || st_r.gate_a),
		.done    (b_done)
	);

	// ----------------------------------------------------------------
	// Fault conditions
	// ----------------------------------------------------------------
	// Supply fault on any side stops both gates
	assign block_all = supply_fault_primary || supply_fault_a || supply_fault_b
		|| st_r.overtemp;
	// Over-current and clamp act on their own channel; over-current latched until cleared
	assign stop_a = block_all || overcurrent_a || clamp_trip_a || st_r.oc_hold_a;
	assign stop_b = block_all || overcurrent_b || clamp_trip_b || st_r.oc_hold_b;
	// Primary supply fault reported on both flags
	assign cond_a = overcurrent_a || supply_fault_a || supply_fault_primary;
	assign cond_b = overcurrent_b || supply_fault_b || supply_fault_primary;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A has priority; B is forced off combinationally in the same cycle
	always_comb begin
		st_nxt         = st_r;
		st_nxt.cmd_a_q = channel_a_command;
		// Over-temperature with hysteresis between two comparator levels
		if (temp_above_high) begin
			st_nxt.overtemp = 1'b1;
		end else if (temp_below_low) begin
			st_nxt.overtemp = 1'b0;
		end
		// Over-current holds the channel off until the host clears it
		if (overcurrent_a) begin
			st_nxt.oc_hold_a = 1'b1;
		end else if (fault_clear_input) begin
			st_nxt.oc_hold_a = 1'b0;
		end
		if (overcurrent_b) begin
			st_nxt.oc_hold_b = 1'b1;
		end else if (fault_clear_input) begin
			st_nxt.oc_hold_b = 1'b0;
		end
		// Gate A: on after dead time when B is off
		st_nxt.gate_a = channel_a_command && a_done && !st_r.gate_b && !stop_a;
		// Gate B: only while A command low and A gate off, after dead time
		st_nxt.gate_b = channel_b_command && !channel_a_command
			&& !st_r.gate_a && b_done && !stop_b;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r.cmd_a_q   <= 1'b0;
			st_r.gate_a    <= hbif_pkg::RST_GATE;
			st_r.gate_b    <= hbif_pkg::RST_GATE;
			st_r.overtemp  <= hbif_pkg::RST_FLAG;
			st_r.oc_hold_a <= hbif_pkg::RST_FLAG;
			st_r.oc_hold_b <= hbif_pkg::RST_FLAG;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Immediate cut: gates fall in the same cycle as the cause, over-temperature one edge later
	assign gate_a = st_r.gate_a && !stop_a;
	assign gate_b = st_r.gate_b && !stop_b && !channel_a_command;
	assign overtemp_flag = st_r.overtemp;

	// Sticky per-driver fault flags
	hbif_fault_latch u_flt_a (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.cond    (cond_a),
		.clear   (fault_clear_input),
		.flag    (first_driver_fault_flag)
	);

	hbif_fault_latch u_flt_b (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.cond    (cond_b),
		.clear   (fault_clear_input),
		.flag    (second_driver_fault_flag)
	);
endmodule
`default_nettype wire

// ===== verification/hbif_sva.sv
// Purpose: Port assertions for the interlock and fault block
// Assumes: One clock domain, reset_n asynchronous active low
// Notes:   Dead time windows accept gate A 8 to 12 cycles after the trigger, gate B 8 to 13
`timescale 1ns/1ps
`default_nettype none
module hbif_sva (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic channel_a_command,
	input wire logic channel_b_command,
	input wire logic fault_clear_input,
	input wire logic overcurrent_a,
	input wire logic clamp_trip_a,
	input wire logic supply_fault_primary,
	input wire logic supply_fault_a,
	input wire logic temp_above_high,
	input wire logic temp_below_low,
	input wire logic gate_a,
	input wire logic gate_b,
	input wire logic first_driver_fault_flag,
	input wire logic second_driver_fault_flag,
	input wire logic overtemp_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Kills act in the cycle of their cause, over-temperature kill and flags one edge later
	no_overlap_a: assert property (!(gate_a && gate_b))
		else $error("both gates on");
	a_kills_b_a: assert property (channel_a_command |-> !gate_b)
		else $error("gate b not dropped");
	preempt_wait_a: assert property ($fell(gate_b) && channel_a_command |->
		!gate_a [*8] ##[1:5] gate_a) else $error("gate a dead time");
	b_resume_a: assert property ($fell(channel_a_command) && channel_b_command |->
		!gate_b [*8] ##[1:6] gate_b) else $error("gate b dead time");
	oc_kill_a: assert property (overcurrent_a |-> !gate_a ##1 first_driver_fault_flag)
		else $error("over-current not handled");
	clamp_off_a: assert property (clamp_trip_a |-> !gate_a)
		else $error("clamp not handled");
	supply_lock_a: assert property (supply_fault_primary |-> !gate_a && !gate_b ##1
		first_driver_fault_flag && second_driver_fault_flag) else $error("supply lock");
	temp_lock_a: assert property (temp_above_high |=> overtemp_flag && !gate_a && !gate_b)
		else $error("overtemp lock");
	temp_band_a: assert property (overtemp_flag && !temp_below_low |=> overtemp_flag)
		else $error("overtemp released early");
	flag_hold_a: assert property (first_driver_fault_flag && !fault_clear_input |=>
		first_driver_fault_flag) else $error("flag lost");
	flag_clear_a: assert property (fault_clear_input && !overcurrent_a &&
		!supply_fault_primary && !supply_fault_a |=> !first_driver_fault_flag)
		else $error("flag not cleared");
	cover property ($fell(gate_b) && channel_a_command);
	cover property ($fell(channel_a_command) && channel_b_command);
	cover property (fault_clear_input && first_driver_fault_flag);
endmodule
bind hbif_top hbif_sva chk_u (.ref_clk, .reset_n, .channel_a_command, .channel_b_command,
	.fault_clear_input, .overcurrent_a, .clamp_trip_a, .supply_fault_primary,
	.supply_fault_a, .temp_above_high, .temp_below_low, .gate_a, .gate_b,
	.first_driver_fault_flag, .second_driver_fault_flag, .overtemp_flag);
`default_nettype wire

// ===== verification/hbif_host_model.sv
// Purpose: Host side that shapes the two gate commands
// Assumes: Wanted levels change at ref_clk edges
// Notes:   Each level stands 13 cycles at least
`timescale 1ns/1ps
`default_nettype none
module hbif_host_model (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic want_a,
	input  wire logic want_b,
	output logic      channel_a_command,
	output logic      channel_b_command
);
	logic [3:0] hold_a_r;
	logic [3:0] hold_b_r;
	// Short pulses are never sent; a late request waits out the hold
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{channel_a_command, channel_b_command, hold_a_r, hold_b_r} <= 10'h000;
		end else begin
			if (hold_a_r != 4'h0) hold_a_r <= hold_a_r - 4'h1;
			else if (want_a != channel_a_command) {channel_a_command, hold_a_r} <= {want_a, 4'hC};
			if (hold_b_r != 4'h0) hold_b_r <= hold_b_r - 4'h1;
			else if (want_b != channel_b_command) {channel_b_command, hold_b_r} <= {want_b, 4'hC};
		end
	end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the interlock and fault block
// Assumes: Host model shapes the gate commands
// Notes:   Dead time accepted within 10 to 12 edges for gate A, 9 to 11 for gate B
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       ref_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       want_a = 1'b0, want_b = 1'b0, clr = 1'b0, hot = 1'b0, cool = 1'b1;
	logic       en = 1'b1;
	logic [6:0] cond = 7'h00;
	wire logic  cmd_a, cmd_b, gate_a, gate_b, fl1, fl2, ot;
	int         error_cnt = 0, tests_run = 0, n, tmo = 0;
	always #20 ref_clk = ~ref_clk;
	hbif_host_model host_u (.ref_clk, .reset_n, .want_a, .want_b,
		.channel_a_command(cmd_a), .channel_b_command(cmd_b));
	hbif_top dut_u (.ref_clk, .reset_n, .clk_en(en), .channel_a_command(cmd_a),
		.channel_b_command(cmd_b), .fault_clear_input(clr), .overcurrent_a(cond[0]),
		.overcurrent_b(cond[1]), .clamp_trip_a(cond[2]), .clamp_trip_b(cond[3]),
		.supply_fault_primary(cond[4]), .supply_fault_a(cond[5]), .supply_fault_b(cond[6]),
		.temp_above_high(hot), .temp_below_low(cool), .gate_a, .gate_b,
		.first_driver_fault_flag(fl1), .second_driver_fault_flag(fl2), .overtemp_flag(ot));
	task step; @(posedge ref_clk); #1; endtask
	task chk(string nm, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin error_cnt++; $display("ERROR %s exp %0h seen %0h", nm, exp, seen); end
	endtask
	task set_w(logic a, logic b, int hold);
		@(posedge ref_clk); want_a <= a; want_b <= b;
		repeat (hold) step;
	endtask
	// Edges from the call until the chosen gate rises, at most 30
	task meas(logic sel);
		n = 0;
		while ((sel ? gate_b : gate_a) !== 1'b1 && n < 30) begin step; n++; end
	endtask
	task t_interlock;
		set_w(1'b0, 1'b1, 20);
		set_w(1'b1, 1'b1, 1);
		chk("b killed", gate_b, 0);
		meas(1'b0);
		chk("a dead time", n >= 10 && n <= 12, 1);
		set_w(1'b0, 1'b1, 2);
		meas(1'b1);
		chk("b dead time", n >= 9 && n <= 11, 1);
		set_w(1'b0, 1'b0, 20);
		set_w(1'b1, 1'b0, 20);
		set_w(1'b1, 1'b1, 20);
		chk("b ignored", gate_b, 0);
		set_w(1'b0, 1'b1, 2);
		meas(1'b1);
		chk("b pending", n >= 9 && n <= 11, 1);
		set_w(1'b1, 1'b0, 20);
	endtask
	// Each fault input in turn while gate A runs; a clear pulse after each
	task t_faults;
		for (int k = 0; k < 7; k++) begin
			@(posedge ref_clk); cond <= 7'h01 << k;
			step;
			if ((7'h35 >> k) & 7'h01) chk("a killed", gate_a, 0);
			step;
			chk("flag a", fl1, (7'h31 >> k) & 7'h01);
			chk("flag b", fl2, (7'h52 >> k) & 7'h01);
			@(posedge ref_clk); cond <= 7'h00;
			repeat (3) step;
			chk("flag a held", {fl1, fl2}, {1'((7'h31 >> k) & 7'h01), 1'((7'h52 >> k) & 7'h01)});
			@(posedge ref_clk); clr <= 1'b1;
			@(posedge ref_clk); clr <= 1'b0;
			step;
			chk("flags cleared", {fl1, fl2}, 0);
			repeat (15) step;
			chk("a restored", gate_a, 1);
		end
	endtask
	task t_temp;
		@(posedge ref_clk); hot <= 1'b1; cool <= 1'b0;
		repeat (2) step;
		chk("hot lock", {ot, gate_a, gate_b}, 4);
		@(posedge ref_clk); hot <= 1'b0;
		repeat (5) step;
		chk("band hold", ot, 1);
		@(posedge ref_clk); cool <= 1'b1;
		repeat (15) step;
		chk("cool resume", {ot, gate_a}, 1);
	endtask
	// Enable low freezes the gate register even though A has dropped
	task t_freeze;
		@(posedge ref_clk); en <= 1'b0; want_a <= 1'b0;
		repeat (4) step;
		chk("frozen gate", gate_a, 1);
		@(posedge ref_clk); en <= 1'b1;
		repeat (2) step;
		chk("resumed off", gate_a, 0);
	endtask
	task final_report;
		if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) step;
		t_interlock;
		t_faults;
		t_temp;
		t_freeze;
		final_report;
	end
	// Run needs about 370 cycles; a hang ends well past that
	always @(posedge ref_clk) begin
		tmo++;
		if (tmo == 5000) begin error_cnt++; final_report; end
	end
endmodule
`default_nettype wire
